// File: hdl/aoc_pkg.sv
// Package with register map, field layout and timing constants for the block
package aoc_pkg;
  localparam logic [9:0] ADDR_THR0 = 10'h211;
  localparam logic [9:0] ADDR_THR1 = 10'h212;
  localparam logic [9:0] ADDR_RANGE_CFG = 10'h213;
  localparam logic [9:0] ADDR_CAL_EN = 10'h2b0;
  localparam logic [9:0] ADDR_CAL_CFG = 10'h2b1;
  localparam logic [9:0] ADDR_PWR_DN = 10'h209;
  localparam logic [9:0] ADDR_CAL_STAT = 10'h2b2;
  localparam logic [9:0] ADDR_MAN_DLY = 10'h2b5;
  localparam logic [7:0] RST_THR0 = 8'hf2;
  localparam logic [7:0] RST_THR1 = 8'hab;
  localparam logic [7:0] RST_RANGE_CFG = 8'h07;
  localparam logic [7:0] RST_CAL_EN = 8'h00;
  localparam logic [7:0] RST_CAL_CFG = 8'h05;
  localparam logic [7:0] RST_PWR_DN = 8'h00;
  localparam int PWR_DN_A_BIT = 0;
  localparam int PWR_DN_B_BIT = 1;
  localparam int RANGE_EN_BIT = 3;
  localparam int RANGE_LEN_LSB = 0;
  localparam int AVG_LSB = 2;
  localparam int HDUR_LSB = 0;
  localparam int DONE_BIT = 17;
  localparam int INV_BIT = 16;
  localparam int PULSE_BASE_LOG2 = 3;
  localparam int CAL_UNIT = 256 * 19 * 4;
  localparam logic [14:0] PER_LIM0 = 15'h0055;
  localparam logic [14:0] PER_LIM1 = 15'h044c;
  localparam logic [14:0] PER_LIM2 = 15'h1450;
  localparam logic [14:0] PER_LIM3 = 15'h544c;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN = 2'b01,
    CAL_DONE = 2'b10,
    CAL_FAIL = 2'b11
  } aoc_cal_e;
endpackage : aoc_pkg

// File: hdl/aoc_if.sv
// Interface joining the converter control end and the host end
`timescale 1ns/10ps
interface aoc_if;
  logic [9:0] addr;
  logic [23:0] wdata;
  logic wr;
  logic rd;
  logic [23:0] rdata;
  logic [3:0] range_pins;
  modport dev (input addr, input wdata, input wr, input rd,
    output rdata, output range_pins);
  modport host (output addr, output wdata, output wr, output rd,
    input rdata, input range_pins);
endinterface : aoc_if

// File: hdl/aoc_dev.sv
// Converter end: registers, overrange detection and SYSREF calibration
`timescale 1ns/10ps
module aoc_dev #(
  parameter int CAL_SCALE = aoc_pkg::CAL_UNIT
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  aoc_if.dev bus,
  input wire logic [11:0] i_samp_a,
  input wire logic [11:0] i_samp_b,
  input wire logic i_sysref,
  input wire logic i_cal_phase_done,
  input wire logic [16:0] i_cal_phase_val,
  output logic o_chan_a_on,
  output logic o_chan_b_on,
  output logic [11:0] o_lane_en_a,
  output logic [11:0] o_lane_en_b,
  output logic [1:0] o_bus_frame_strobe_en,
  output logic [1:0] o_bus_data_clock_en,
  output logic [16:0] o_aperture_delay
);
  logic [7:0] thr0_q, thr1_q, range_cfg_q, cal_en_q, cal_cfg_q, pwr_dn_q;
  logic [15:0] man_dly_q;
  logic [23:0] rdata_q;
  logic cal_en_d1_q;
  aoc_pkg::aoc_cal_e cal_q;
  logic [31:0] cal_cnt_q;
  logic [14:0] per_cnt_q;
  logic sysref_d_q;
  logic [16:0] result_q;
  logic [31:0] cal_lim;
  logic [14:0] per_lim;
  logic sysref_rise, cal_start;
  logic [3:0] hit;
  logic [3:0] pins_q;
  logic [10:0] hold_q [4];
  logic [7:0] mag [2];
  logic [10:0] hold_len;

  // Magnitude of a 12-bit two's complement sample, as a /256 fraction
  function automatic logic [7:0] fs_frac(input logic [11:0] s);
    logic [11:0] m;
    m = s[11] ? ~s : s;
    return m[10:3];
  endfunction : fs_frac

  function automatic logic [14:0] period_limit(input logic [1:0] c);
    case (c)
      2'd0: return aoc_pkg::PER_LIM0;
      2'd1: return aoc_pkg::PER_LIM1;
      2'd2: return aoc_pkg::PER_LIM2;
      default: return aoc_pkg::PER_LIM3;
    endcase
  endfunction : period_limit

  // Channel power-down drives lane, strobe and clock enables
  assign o_chan_a_on = ~pwr_dn_q[aoc_pkg::PWR_DN_A_BIT];
  assign o_chan_b_on = ~pwr_dn_q[aoc_pkg::PWR_DN_B_BIT];
  assign o_lane_en_a = {12{o_chan_a_on}};
  assign o_lane_en_b = {12{o_chan_b_on}};
  assign o_bus_frame_strobe_en = {o_chan_b_on, o_chan_a_on};
  assign o_bus_data_clock_en = {o_chan_b_on, o_chan_a_on};

  // Threshold compare on the 8-bit fraction of full scale
  assign mag[0] = fs_frac(i_samp_a);
  assign mag[1] = fs_frac(i_samp_b);
  assign hit[0] = o_chan_a_on && mag[0] >= thr0_q;
  assign hit[1] = o_chan_a_on && mag[0] >= thr1_q;
  assign hit[2] = o_chan_b_on && mag[1] >= thr0_q;
  assign hit[3] = o_chan_b_on && mag[1] >= thr1_q;
  assign hold_len = 11'(1) << (aoc_pkg::PULSE_BASE_LOG2
    + int'(range_cfg_q[2:0]));
  assign bus.range_pins = range_cfg_q[aoc_pkg::RANGE_EN_BIT] ? pins_q
    : 4'h0;

  // Each flag holds for 8*2^N cycles, restarted by every new crossing
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_flag
      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          hold_q[g] <= 11'h000;
          pins_q[g] <= 1'b0;
        end else if (hit[g]) begin
          hold_q[g] <= hold_len - 11'h001;
          pins_q[g] <= 1'b1;
        end else if (hold_q[g] != 11'h000) begin
          hold_q[g] <= hold_q[g] - 11'h001;
        end else begin
          pins_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Calibration bound and supported SYSREF period from the config
  assign cal_lim = 32'(CAL_SCALE) * (32'(cal_cfg_q[3:2])
    + 32'(cal_cfg_q[1:0]) + 32'd2);
  assign per_lim = period_limit(cal_cfg_q[1:0]);
  assign sysref_rise = i_sysref && !sysref_d_q;
  assign cal_start = cal_en_q[0] && !cal_en_d1_q;
  // Manual delay only while calibration is off
  assign o_aperture_delay = cal_en_q[0] ? result_q
    : {1'b0, man_dly_q};

  // Calibration sequencer; a write of 0 to the enable abandons it
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cal_q <= aoc_pkg::CAL_IDLE;
      cal_cnt_q <= 32'h0;
      per_cnt_q <= 15'h0;
      result_q <= 17'h0;
      cal_en_d1_q <= 1'b0;
      sysref_d_q <= 1'b0;
    end else begin
      cal_en_d1_q <= cal_en_q[0];
      sysref_d_q <= i_sysref;
      case (cal_q)
        aoc_pkg::CAL_IDLE: begin
          if (cal_start) begin
            cal_q <= aoc_pkg::CAL_RUN;
            cal_cnt_q <= 32'h0;
            per_cnt_q <= 15'h0;
          end
        end
        aoc_pkg::CAL_RUN: begin
          cal_cnt_q <= cal_cnt_q + 32'h1;
          per_cnt_q <= sysref_rise ? 15'h0 : per_cnt_q + 15'h1;
          if (!cal_en_q[0]) begin
            cal_q <= aoc_pkg::CAL_IDLE;
          end else if (per_cnt_q > per_lim) begin
            cal_q <= aoc_pkg::CAL_FAIL;
          end else if (i_cal_phase_done
              || cal_cnt_q >= cal_lim - 32'h1) begin
            result_q <= i_cal_phase_val;
            cal_q <= aoc_pkg::CAL_DONE;
          end
        end
        aoc_pkg::CAL_DONE, aoc_pkg::CAL_FAIL: begin
          if (!cal_en_q[0]) begin
            cal_q <= aoc_pkg::CAL_IDLE;
          end
        end
        default: cal_q <= aoc_pkg::CAL_IDLE;
      endcase
    end
  end

  // Register writes; reserved bits are stored as zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      thr0_q <= aoc_pkg::RST_THR0;
      thr1_q <= aoc_pkg::RST_THR1;
      range_cfg_q <= aoc_pkg::RST_RANGE_CFG;
      cal_en_q <= aoc_pkg::RST_CAL_EN;
      cal_cfg_q <= aoc_pkg::RST_CAL_CFG;
      pwr_dn_q <= aoc_pkg::RST_PWR_DN;
      man_dly_q <= 16'h0000;
    end else if (bus.wr) begin
      case (bus.addr)
        aoc_pkg::ADDR_THR0: thr0_q <= bus.wdata[7:0];
        aoc_pkg::ADDR_THR1: thr1_q <= bus.wdata[7:0];
        aoc_pkg::ADDR_RANGE_CFG: range_cfg_q <= {4'h0, bus.wdata[3:0]};
        aoc_pkg::ADDR_CAL_EN: cal_en_q <= {7'h00, bus.wdata[0]};
        aoc_pkg::ADDR_CAL_CFG: cal_cfg_q <= {4'h0, bus.wdata[3:0]};
        aoc_pkg::ADDR_PWR_DN: pwr_dn_q <= {6'h00, bus.wdata[1:0]};
        aoc_pkg::ADDR_MAN_DLY: man_dly_q <= bus.wdata[15:0];
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rdata_q <= 24'h0;
    end else if (bus.rd) begin
      case (bus.addr)
        aoc_pkg::ADDR_THR0: rdata_q <= {16'h0, thr0_q};
        aoc_pkg::ADDR_THR1: rdata_q <= {16'h0, thr1_q};
        aoc_pkg::ADDR_RANGE_CFG: rdata_q <= {16'h0, range_cfg_q};
        aoc_pkg::ADDR_CAL_EN: rdata_q <= {16'h0, cal_en_q};
        aoc_pkg::ADDR_CAL_CFG: rdata_q <= {16'h0, cal_cfg_q};
        aoc_pkg::ADDR_PWR_DN: rdata_q <= {16'h0, pwr_dn_q};
        aoc_pkg::ADDR_MAN_DLY: rdata_q <= {8'h0, man_dly_q};
        aoc_pkg::ADDR_CAL_STAT: rdata_q <= {6'h0,
          cal_q == aoc_pkg::CAL_DONE && cal_en_q[0], result_q};
        default: rdata_q <= 24'h0;
      endcase
    end else begin
      rdata_q <= 24'h0;
    end
  end
  assign bus.rdata = rdata_q;
endmodule : aoc_dev

// File: hdl/aoc_host.sv
// Host end: forwards software accesses, guards power-down, holds flags
`timescale 1ns/10ps
module aoc_host (
  input wire logic i_clk,
  input wire logic i_rst_b,
  aoc_if.host bus,
  input wire logic [9:0] i_addr,
  input wire logic [23:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_lanes_off,
  input wire logic i_conv_cal_busy,
  output logic [23:0] o_rdata,
  output logic [3:0] o_range,
  output logic o_refused
);
  logic [9:0] addr_q;
  logic [23:0] wdata_q;
  logic wr_q, rd_q;
  logic [23:0] rdata_q;
  logic [3:0] range_q;
  logic refused_q;
  logic cal_on_q;
  logic bad_pd, bad_en, bad;

  // Guard writes that break the far end's ordering
  assign bad_pd = i_addr == aoc_pkg::ADDR_PWR_DN && (cal_on_q
    || !i_lanes_off || i_wdata[1:0] == 2'b11);
  assign bad_en = i_addr == aoc_pkg::ADDR_CAL_EN && i_wdata[0]
    && i_conv_cal_busy;
  assign bad = i_wr && (bad_pd || bad_en);

  // Registered request stage; config must precede enable by order
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      addr_q <= 10'h0;
      wdata_q <= 24'h0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      refused_q <= 1'b0;
      cal_on_q <= 1'b0;
    end else begin
      addr_q <= i_addr;
      wdata_q <= i_wdata;
      wr_q <= i_wr && !bad;
      rd_q <= i_rd;
      refused_q <= bad;
      if (i_wr && !bad && i_addr == aoc_pkg::ADDR_CAL_EN) begin
        cal_on_q <= i_wdata[0];
      end
    end
  end

  // Read data and flag capture
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rdata_q <= 24'h0;
      range_q <= 4'h0;
    end else begin
      rdata_q <= bus.rdata;
      range_q <= bus.range_pins;
    end
  end

  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.wr = wr_q;
  assign bus.rd = rd_q;
  assign o_rdata = rdata_q;
  assign o_range = range_q;
  assign o_refused = refused_q;
endmodule : aoc_host

// File: sim/aoc_properties.sv
// Checker on the link between the host end and the converter end
`timescale 1ns/10ps
module aoc_properties (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [9:0] addr,
  input wire logic [23:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [23:0] rdata,
  input wire logic [3:0] range_pins
);
  logic [7:0] t0_q;
  logic [3:0] cfg_q;
  logic [3:0] ccfg_q;
  logic en_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Shadow of THR0, range config, cal config and cal enable; reserved bits are kept at zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      t0_q <= 8'hf2;
      cfg_q <= 4'h7;
      ccfg_q <= 4'h5;
      en_q <= 1'b0;
    end else if (wr) begin
      if (addr == aoc_pkg::ADDR_THR0) t0_q <= wdata[7:0];
      if (addr == aoc_pkg::ADDR_RANGE_CFG) cfg_q <= wdata[3:0];
      if (addr == aoc_pkg::ADDR_CAL_CFG) ccfg_q <= wdata[3:0];
      if (addr == aoc_pkg::ADDR_CAL_EN) en_q <= wdata[0];
    end
  end
  property p_thr0;
    rd && addr == aoc_pkg::ADDR_THR0 |=> rdata == {16'h0000, t0_q};
  endproperty
  a_thr0: assert property (p_thr0)
    else $error("threshold readback off");
  property p_cfg;
    rd && addr == aoc_pkg::ADDR_RANGE_CFG |=> rdata[7:0] == {4'h0, cfg_q};
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("overrange config readback off");
  property p_ccfg;
    rd && addr == aoc_pkg::ADDR_CAL_CFG |=> rdata[7:0] == {4'h0, ccfg_q};
  endproperty
  a_ccfg: assert property (p_ccfg)
    else $error("calibration config readback off");
  property p_cen;
    rd && addr == aoc_pkg::ADDR_CAL_EN |=> rdata == {23'h000000, en_q};
  endproperty
  a_cen: assert property (p_cen)
    else $error("calibration enable readback off");
  property p_off;
    !cfg_q[3] |-> range_pins == 4'h0;
  endproperty
  a_off: assert property (p_off)
    else $error("range pins active while disabled");
  property p_pa;
    $rose(range_pins[0]) && cfg_q == 4'h8 |-> range_pins[0] [*8];
  endproperty
  a_pa: assert property (p_pa)
    else $error("channel a pulse too short");
  property p_pb;
    $rose(range_pins[2]) && cfg_q == 4'h8 |-> range_pins[2] [*8];
  endproperty
  a_pb: assert property (p_pb)
    else $error("channel b pulse too short");
  property p_done;
    rd && addr == aoc_pkg::ADDR_CAL_STAT && !en_q |=> !rdata[17];
  endproperty
  a_done: assert property (p_done)
    else $error("done shown while calibration disabled");
  c_pulse: cover property ($rose(range_pins[0]));
  c_cal: cover property (rd && addr == aoc_pkg::ADDR_CAL_STAT ##1 rdata[17]);
  c_gate: cover property (!cfg_q[3] && wr);
endmodule : aoc_properties

// File: sim/tb.sv
// Self-checking bench joining both ends through the shared interface
`timescale 1ns/10ps
module tb;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [9:0] h_a = 10'h000;
  logic [23:0] h_d = 24'h000000;
  logic h_wr = 1'b0, h_rd = 1'b0, loff = 1'b1, busy = 1'b0, sr_on = 1'b1;
  logic sysref = 1'b0, refused, ref_seen, a_on, b_on;
  logic [11:0] sa = 12'h000, sb = 12'h000, la, lb;
  logic [23:0] rdat, v;
  logic [3:0] rng;
  logic [1:0] stb, dck;
  logic [16:0] dly;
  logic [23:0] pwr_view;
  logic [4:0] sr_cnt = 5'h00;
  int bad_count = 0, total_checks = 0, n;
  aoc_if aoc_if_i ();
  // Scale long enough that a missing reference edge fails before done
  aoc_dev #(.CAL_SCALE(64)) aoc_dev_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .bus(aoc_if_i), .i_samp_a(sa), .i_samp_b(sb), .i_sysref(sysref),
    .i_cal_phase_done(1'b0), .i_cal_phase_val(17'h1abcd),
    .o_chan_a_on(a_on), .o_chan_b_on(b_on), .o_lane_en_a(la),
    .o_lane_en_b(lb), .o_bus_frame_strobe_en(stb),
    .o_bus_data_clock_en(dck), .o_aperture_delay(dly));
  aoc_host aoc_host_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(aoc_if_i),
    .i_addr(h_a), .i_wdata(h_d), .i_wr(h_wr), .i_rd(h_rd),
    .i_lanes_off(loff), .i_conv_cal_busy(busy), .o_rdata(rdat),
    .o_range(rng), .o_refused(refused));
  aoc_properties aoc_properties_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .addr(aoc_if_i.addr), .wdata(aoc_if_i.wdata), .wr(aoc_if_i.wr),
    .rd(aoc_if_i.rd), .rdata(aoc_if_i.rdata),
    .range_pins(aoc_if_i.range_pins));
  always #2 i_clk = ~i_clk;
  // Power-down view: channel on bits, strobe and clock enables, A lanes
  assign pwr_view = {6'h0, a_on, b_on, stb, dck, la};
  // Reference edge every 32 cycles, inside the shortest supported period
  always @(posedge i_clk) begin
    sr_cnt <= sr_cnt + 5'h01;
    sysref <= sr_on && sr_cnt == 5'h00;
  end
  task automatic cmp(input string w, input logic [23:0] e, logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", w, e, g);
    end
  endtask : cmp
  // Refusal pulse is caught in any of the four cycles after the strobe
  task automatic wr(input logic [9:0] a, input logic [23:0] d);
    @(posedge i_clk);
    h_a <= a;
    h_d <= d;
    h_wr <= 1'b1;
    ref_seen = 1'b0;
    repeat (4) begin
      @(posedge i_clk);
      h_wr <= 1'b0;
      #1 ref_seen |= refused;
    end
  endtask : wr
  task automatic rd(input logic [9:0] a);
    @(posedge i_clk);
    h_a <= a;
    h_rd <= 1'b1;
    repeat (3) begin
      @(posedge i_clk);
      h_rd <= 1'b0;
    end
    #1 v = rdat;
  endtask : rd
  task automatic rc(input logic [9:0] a, input logic [23:0] e, string w);
    rd(a);
    cmp(w, e, v);
  endtask : rc
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rc(aoc_pkg::ADDR_THR0, 24'hf2, "thr0");
    rc(aoc_pkg::ADDR_THR1, 24'hab, "thr1");
    rc(aoc_pkg::ADDR_RANGE_CFG, 24'h07, "range cfg");
    rc(aoc_pkg::ADDR_CAL_CFG, 24'h05, "cal cfg");
    rc(10'h3ff, 24'h0, "unmapped");
    $display("test reset done");
    wr(aoc_pkg::ADDR_THR0, 24'h40);
    wr(aoc_pkg::ADDR_THR1, 24'h80);
    wr(aoc_pkg::ADDR_RANGE_CFG, 24'h08);
    sa <= 12'h1ff;
    repeat (6) @(posedge i_clk);
    cmp("below", 24'h0, {20'h0, rng});
    sa <= 12'h200;
    sb <= 12'hbff;
    repeat (6) @(posedge i_clk);
    cmp("hits", 24'hd, {20'h0, rng});
    sb <= 12'h000;
    repeat (14) @(posedge i_clk);
    cmp("b ends", 24'h1, {20'h0, rng});
    sa <= 12'h000;
    n = 0;
    while (rng[0] !== 1'b0 && n < 40) begin
      @(posedge i_clk);
      #1 n++;
    end
    cmp("pulse", 24'h1, {23'h0, n >= 8 && n <= 12});
    // Gate first, so no running pulse is cut; the new hit must stay hidden
    wr(aoc_pkg::ADDR_RANGE_CFG, 24'h00);
    sa <= 12'h200;
    repeat (4) @(posedge i_clk);
    cmp("gated", 24'h0, {20'h0, rng});
    $display("test overrange done");
    wr(aoc_pkg::ADDR_PWR_DN, 24'h01);
    cmp("a down", 24'h01a000, pwr_view);
    wr(aoc_pkg::ADDR_PWR_DN, 24'h03);
    cmp("both refused", 24'h1, {23'h0, ref_seen});
    loff <= 1'b0;
    wr(aoc_pkg::ADDR_PWR_DN, 24'h00);
    cmp("lanes refused", 24'h1, {23'h0, ref_seen});
    loff <= 1'b1;
    wr(aoc_pkg::ADDR_PWR_DN, 24'h00);
    cmp("a up", 24'h03ffff, pwr_view);
    $display("test power down done");
    wr(aoc_pkg::ADDR_MAN_DLY, 24'h001234);
    cmp("manual", 24'h1234, {7'h0, dly});
    wr(aoc_pkg::ADDR_CAL_CFG, 24'h00);
    busy <= 1'b1;
    wr(aoc_pkg::ADDR_CAL_EN, 24'h01);
    cmp("busy refused", 24'h1, {23'h0, ref_seen});
    busy <= 1'b0;
    wr(aoc_pkg::ADDR_CAL_EN, 24'h01);
    // Bound is 64 * (0 + 0 + 2) cycles from the start edge
    repeat (128) @(posedge i_clk);
    rc(aoc_pkg::ADDR_CAL_STAT, 24'h03abcd, "status");
    cmp("auto", 24'h1abcd, {7'h0, dly});
    wr(aoc_pkg::ADDR_CAL_EN, 24'h01);
    rc(aoc_pkg::ADDR_CAL_STAT, 24'h03abcd, "no restart");
    wr(aoc_pkg::ADDR_CAL_EN, 24'h00);
    sr_on <= 1'b0;
    wr(aoc_pkg::ADDR_CAL_EN, 24'h01);
    // Look after the point where a run without failure would be done
    repeat (200) @(posedge i_clk);
    rd(aoc_pkg::ADDR_CAL_STAT);
    cmp("fail", 24'h0, {23'h0, v[17]});
    wr(aoc_pkg::ADDR_RANGE_CFG, 24'h0f);
    rc(aoc_pkg::ADDR_RANGE_CFG, 24'h0f, "max length");
    $display("test calibration done");
    conclude();
  end
endmodule : tb
